// ==== rtl/anode_segment_finder.sv ====
// anode track-segment finder: roads, pre-trigger, sorting, output and raw readout
`timescale 1ns/100ps
// Summary of operation
// - sample per crossing, tag first n-layer coincidence
// - count layers per road against two levels
// - wait fixed delay before pattern level test
// - per-channel fine delay, 3-bit, 4 ns steps rounded to 5 ns taps
// - masked channels never contribute hits
// - stretch each unmasked hit programmably
// - pointing and parallel families, each disableable
// - struck layer count is 3-bit quality
// - sort key is type bit over quality
// - one best candidate per 16 groups
// - equal keys prefer group farthest from beam
// - keep the best candidates of the two best spans over chamber
// - 16-bit word valid quality parallel position crossing
// - valid only during the transmitting cycle
// - quality field is layers hit minus three, zero below three layers
// - position 0-111 at third layer
// - parallel bit marks beam-parallel pattern found
// - carry five low crossing counter bits
// - freeze raw hits, read out on accept
// - at most two segments sent
module anode_segment_finder (
    input  wire logic                  clock,         // 200 MHz system clock
    input  wire logic                  srst,          // synchronous reset, high
    input  wire seg_pkg::hit_plane_t   hit_pins,      // discriminator pins
    input  wire seg_pkg::delay_plane_t delay_sel,     // fine delay settings
    input  wire seg_pkg::hit_plane_t   chan_mask,     // channel mask
    input  wire logic [2:0]            stretch_bx,    // stretch length, crossings
    input  wire logic [2:0]            pretrig_level, // pre-trigger layers
    input  wire logic [2:0]            pattern_level, // pattern layers
    input  wire logic                  coll_enable,   // pointing family on
    input  wire logic                  accel_enable,  // beam-parallel family on
    input  wire logic                  coll_high,     // type bit polarity
    input  wire logic                  level1_accept, // accept strobe
    input  wire logic [11:0]           level1_bxn,    // accepted crossing
    output logic      [15:0]           seg0_word,     // best segment
    output logic      [15:0]           seg1_word,     // second segment
    output logic                       pretrig_pulse, // crossing tagged
    output logic      [11:0]           bx_number,     // crossing counter
    output logic                       raw_frozen,    // raw store frozen
    output logic                       readout_bit,   // serial raw data
    output logic                       readout_valid  // serial data valid
);
    cond_hits_if hits_bus ();

    logic [2:0]                 bx_div_reg;
    logic [2:0]                 bx_div_next;
    logic                       bx_en;
    logic [11:0]                bxn_reg;
    logic [2:0]                 pre_lvl;
    logic [2:0]                 pat_lvl;
    logic [2:0]                 coll_q [seg_pkg::WIRE_GROUPS];
    logic [2:0]                 accel_q [seg_pkg::WIRE_GROUPS];
    logic [seg_pkg::WIRE_GROUPS-1:0] pre_hit;
    logic                       pretrig_any;
    seg_pkg::cand_t [seg_pkg::WIRE_GROUPS-1:0] cand;
    seg_pkg::cand_t [seg_pkg::SEG_GROUPS-1:0]  grp_best;
    seg_pkg::cand_t             top0;
    seg_pkg::cand_t             top1;
    logic [2:0]                 top_sel;
    seg_pkg::state_t            state_reg;
    seg_pkg::state_t            state_next;
    logic [1:0]                 wait_reg;
    logic [1:0]                 wait_next;
    logic [11:0]                tag_bxn_reg;
    logic [11:0]                tag_next;
    logic                       start_wait;
    logic                       in_sort;
    logic [15:0]                seg0_reg;
    logic [15:0]                seg1_reg;
    logic [3:0]                 key0_reg;
    logic [3:0]                 key1_reg;
    logic                       pretrig_reg;
    logic                       freeze_reg;
    logic [11:0]                frozen_bxn_reg;
    logic                       l1a_match;
    logic                       ro_load_reg;
    logic                       ro_busy_reg;
    logic [9:0]                 ro_cnt_reg;
    logic [seg_pkg::RAW_W-1:0]  ro_shift_reg;
    logic [seg_pkg::RAW_W-1:0]  rd_data;
    logic                       ro_done;

    // a level of zero would fire on empty roads, so it acts as one
    function automatic logic [2:0] clamp_level(input logic [2:0] lvl);
        return (lvl == 3'h0) ? 3'h1 : lvl;
    endfunction

    // layers hit in the road of key group k; pointing roads widen outward
    function automatic logic [2:0] road_count(input seg_pkg::hit_plane_t h, input int k, input logic coll);
        logic [2:0] n;
        logic       hit;
        int         km;
        int         kp;
        n = 3'h0;
        hit = 1'b0;
        km = (k > 0) ? k - 1 : k;
        kp = (k < seg_pkg::WIRE_GROUPS - 1) ? k + 1 : k;
        for (int l = 0; l < seg_pkg::LAYERS; l++) begin
            hit = h[l][k];
            if (coll && l < 2) begin
                hit = hit | h[l][km];
            end
            if (coll && l > 3) begin
                hit = hit | h[l][kp];
            end
            n = n + {2'h0, hit};
        end
        return n;
    endfunction

    // higher key wins; on a tie the higher group, farther from the beam
    function automatic logic better(input seg_pkg::cand_t a, input seg_pkg::cand_t b);
        return a.valid && (!b.valid || a.key > b.key || (a.key == b.key && a.wg > b.wg));
    endfunction

    // best of the two families on one key group
    function automatic seg_pkg::cand_t make_cand(input logic [2:0] cq, input logic [2:0] aq,
                                                 input logic [6:0] wg, input logic ce, input logic ae,
                                                 input logic pol, input logic [2:0] lvl);
        seg_pkg::cand_t c;
        seg_pkg::cand_t a;
        c.valid = ce && (cq >= lvl);
        c.key   = {pol, cq};
        c.accel = 1'b0;
        c.wg    = wg;
        a.valid = ae && (aq >= lvl);
        a.key   = {~pol, aq};
        a.accel = 1'b1;
        a.wg    = wg;
        return better(a, c) ? a : c;
    endfunction

    // priority encoder over one span of adjacent groups
    function automatic seg_pkg::cand_t pick_group(input seg_pkg::cand_t [seg_pkg::GROUP_SPAN-1:0] c);
        seg_pkg::cand_t best;
        best = '0;
        for (int i = 0; i < seg_pkg::GROUP_SPAN; i++) begin
            if (better(c[i], best)) begin
                best = c[i];
            end
        end
        return best;
    endfunction

    // outgoing word; an empty slot is all zero
    function automatic logic [15:0] seg_word(input seg_pkg::cand_t c, input logic [11:0] bxn);
        logic [15:0] w;
        logic [1:0]  q;
        w = 16'h0000;
        q = (c.key[2:0] >= seg_pkg::QUAL_OFFSET) ? 2'(c.key[2:0] - seg_pkg::QUAL_OFFSET) : 2'h0;
        if (c.valid) begin
            w[seg_pkg::SEG_VALID_BIT]         = 1'b1;
            w[seg_pkg::SEG_QUAL_LSB +: 2]     = q;
            w[seg_pkg::SEG_ACCEL_BIT]         = c.accel;
            w[seg_pkg::SEG_WG_LSB +: 7]       = c.wg;
            w[seg_pkg::SEG_BX_LSB +: 5]       = bxn[4:0];
        end
        return w;
    endfunction

    // crossing strobe every five clocks and the crossing counter
    assign bx_en       = (bx_div_reg == seg_pkg::BX_DIV_LAST);
    assign bx_div_next = bx_en ? 3'h0 : bx_div_reg + 3'h1;
    always_ff @(posedge clock) begin
        if (srst) begin
            bx_div_reg <= 3'h0;
            bxn_reg    <= 12'h000;
        end else begin
            bx_div_reg <= bx_div_next;
            bxn_reg    <= bx_en ? bxn_reg + 12'h001 : bxn_reg;
        end
    end

    hit_conditioner u_cond (
        .clock      (clock),
        .srst       (srst),
        .bx_en      (bx_en),
        .hit_pins   (hit_pins),
        .delay_sel  (delay_sel),
        .chan_mask  (chan_mask),
        .stretch_bx (stretch_bx),
        .hp         (hits_bus.producer)
    );

    // road counts and candidates for every key group
    assign pre_lvl = clamp_level(pretrig_level);
    assign pat_lvl = clamp_level(pattern_level);
    for (genvar k = 0; k < seg_pkg::WIRE_GROUPS; k++) begin : g_road
        assign coll_q[k]  = road_count(hits_bus.stretched, k, 1'b1);
        assign accel_q[k] = road_count(hits_bus.stretched, k, 1'b0);
        assign pre_hit[k] = (coll_enable && coll_q[k] >= pre_lvl)
                          || (accel_enable && accel_q[k] >= pre_lvl);
        assign cand[k]    = make_cand(coll_q[k], accel_q[k], 7'(k), coll_enable, accel_enable,
                                      coll_high, pat_lvl);
    end
    assign pretrig_any = |pre_hit;

    // best candidate of each span
    for (genvar g = 0; g < seg_pkg::SEG_GROUPS; g++) begin : g_span
        assign grp_best[g] = pick_group(cand[g*seg_pkg::GROUP_SPAN +: seg_pkg::GROUP_SPAN]);
    end

    // best two spans over the chamber
    always_comb begin
        top0    = '0;
        top1    = '0;
        top_sel = 3'h0;
        for (int g = 0; g < seg_pkg::SEG_GROUPS; g++) begin
            if (better(grp_best[g], top0)) begin
                top0    = grp_best[g];
                top_sel = 3'(g);
            end
        end
        for (int g = 0; g < seg_pkg::SEG_GROUPS; g++) begin
            if (3'(g) != top_sel && better(grp_best[g], top1)) begin
                top1 = grp_best[g];
            end
        end
    end

    // only the first coincidence out of idle tags a crossing
    assign start_wait = (state_reg == seg_pkg::ST_IDLE) && bx_en && pretrig_any;
    assign in_sort    = (state_reg == seg_pkg::ST_SORT);
    always_comb begin
        state_next = state_reg;
        wait_next  = wait_reg;
        tag_next   = tag_bxn_reg;
        unique case (state_reg)
            seg_pkg::ST_IDLE: begin
                if (start_wait) begin
                    state_next = seg_pkg::ST_WAIT;
                    wait_next  = seg_pkg::WAIT_BX - 2'h1; // the sort edge ends the last crossing
                    tag_next   = bxn_reg;
                end
            end
            seg_pkg::ST_WAIT: begin
                if (bx_en && wait_reg == 2'h0) begin
                    state_next = seg_pkg::ST_SORT;
                end else if (bx_en) begin
                    wait_next = wait_reg - 2'h1;
                end
            end
            seg_pkg::ST_SORT: begin
                state_next = seg_pkg::ST_IDLE;
            end
            default: begin
                state_next = seg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg   <= seg_pkg::ST_IDLE;
            wait_reg    <= 2'h0;
            tag_bxn_reg <= 12'h000;
        end else begin
            state_reg   <= state_next;
            wait_reg    <= wait_next;
            tag_bxn_reg <= tag_next;
        end
    end

    // output words live for exactly one clock after the sort
    always_ff @(posedge clock) begin
        if (srst) begin
            seg0_reg    <= 16'h0000;
            seg1_reg    <= 16'h0000;
            key0_reg    <= 4'h0;
            key1_reg    <= 4'h0;
            pretrig_reg <= 1'b0;
        end else begin
            seg0_reg    <= in_sort ? seg_word(top0, tag_bxn_reg) : 16'h0000;
            seg1_reg    <= in_sort ? seg_word(top1, tag_bxn_reg) : 16'h0000;
            key0_reg    <= in_sort ? top0.key : 4'h0;
            key1_reg    <= in_sort ? top1.key : 4'h0;
            pretrig_reg <= start_wait;
        end
    end

    // raw planes stop being overwritten once a segment is found
    assign l1a_match = level1_accept && freeze_reg && !ro_busy_reg && !ro_load_reg
                     && (level1_bxn == frozen_bxn_reg);
    assign ro_done   = ro_busy_reg && (ro_cnt_reg == 10'h000);

    raw_hit_store u_store (
        .clock   (clock),
        .wr_en   (bx_en && !freeze_reg),
        .wr_addr (bxn_reg[seg_pkg::RAW_AW-1:0]),
        .wr_data (hits_bus.raw),
        .rd_en   (l1a_match),
        .rd_addr (frozen_bxn_reg[seg_pkg::RAW_AW-1:0]),
        .rd_data (rd_data)
    );

    // freeze on a found segment, then shift the plane out lsb first
    always_ff @(posedge clock) begin
        if (srst) begin
            freeze_reg     <= 1'b0;
            frozen_bxn_reg <= 12'h000;
            ro_load_reg    <= 1'b0;
            ro_busy_reg    <= 1'b0;
            ro_cnt_reg     <= 10'h000;
            ro_shift_reg   <= '0;
        end else begin
            ro_load_reg <= l1a_match;
            if (ro_done) begin
                freeze_reg <= 1'b0;
            end else if (in_sort && top0.valid && !freeze_reg) begin
                freeze_reg     <= 1'b1;
                frozen_bxn_reg <= tag_bxn_reg;
            end
            if (ro_load_reg) begin
                ro_busy_reg  <= 1'b1;
                ro_cnt_reg   <= seg_pkg::RO_LAST;
                ro_shift_reg <= rd_data;
            end else if (ro_busy_reg) begin
                ro_busy_reg  <= !ro_done;
                ro_cnt_reg   <= ro_done ? 10'h000 : ro_cnt_reg - 10'h001;
                ro_shift_reg <= ro_shift_reg >> 1;
            end
        end
    end

    assign seg0_word     = seg0_reg;
    assign seg1_word     = seg1_reg;
    assign pretrig_pulse = pretrig_reg;
    assign bx_number     = bxn_reg;
    assign raw_frozen    = freeze_reg;
    assign readout_bit   = ro_shift_reg[0];
    assign readout_valid = ro_busy_reg;

    bx_period_a: assert property (@(posedge clock) disable iff (srst)
        bx_en |=> !bx_en [*4] ##1 bx_en) else $error("crossing strobe period wrong");
    wait_time_a: assert property (@(posedge clock) disable iff (srst)
        start_wait |-> ##11 (state_reg == seg_pkg::ST_SORT)) else $error("pattern test not after wait");
    valid_pulse_a: assert property (@(posedge clock) disable iff (srst)
        seg0_reg[15] |-> $past(in_sort) ##1 !seg0_reg[15]) else $error("valid not a single cycle");
    empty_zero_a: assert property (@(posedge clock) disable iff (srst)
        !seg1_reg[15] |-> (seg1_reg == 16'h0000)) else $error("empty slot not zero");
    slot_order_a: assert property (@(posedge clock) disable iff (srst)
        seg1_reg[15] |-> seg0_reg[15]) else $error("second slot valid without first");
    rank_order_a: assert property (@(posedge clock) disable iff (srst)
        (seg0_reg[15] && seg1_reg[15]) |-> (key0_reg >= key1_reg)) else $error("slots out of rank");
    bx_tag_a: assert property (@(posedge clock) disable iff (srst)
        seg0_reg[15] |-> (seg0_reg[4:0] == tag_bxn_reg[4:0])) else $error("crossing bits wrong");
    wg_range_a: assert property (@(posedge clock) disable iff (srst)
        seg0_reg[15] |-> (seg0_reg[11:5] <= seg_pkg::WG_LAST)) else $error("position out of range");
    readout_start_a: assert property (@(posedge clock) disable iff (srst)
        l1a_match |-> ##2 readout_valid && raw_frozen) else $error("readout did not start");
endmodule

// ==== rtl/cond_hits_if.sv ====
// conditioned hit planes passed from the input stage to the finder
`timescale 1ns/100ps
interface cond_hits_if;
    seg_pkg::hit_plane_t raw;        // masked hits latched at the crossing
    seg_pkg::hit_plane_t stretched;  // hits after stretching
    modport producer (output raw, stretched);
    modport consumer (input raw, stretched);
endinterface

// ==== rtl/hit_conditioner.sv ====
// input synchroniser, fine delay, channel mask and pulse stretcher
`timescale 1ns/100ps
module hit_conditioner (
    input  wire logic                  clock,      // system clock
    input  wire logic                  srst,       // synchronous reset
    input  wire logic                  bx_en,      // crossing strobe
    input  wire seg_pkg::hit_plane_t   hit_pins,   // discriminator pins
    input  wire seg_pkg::delay_plane_t delay_sel,  // fine delay per channel
    input  wire seg_pkg::hit_plane_t   chan_mask,  // 1 masks a channel
    input  wire logic [2:0]            stretch_bx, // stretch in crossings
    cond_hits_if.producer              hp          // conditioned hits
);
    seg_pkg::hit_plane_t sync1_reg;
    seg_pkg::hit_plane_t sync2_reg;
    seg_pkg::hit_plane_t dl_reg [seg_pkg::DELAY_TAPS];
    seg_pkg::hit_plane_t delayed;
    seg_pkg::hit_plane_t live;
    seg_pkg::hit_plane_t raw_reg;
    logic [2:0]          cnt_reg [seg_pkg::LAYERS][seg_pkg::WIRE_GROUPS];
    logic [2:0]          load_val;

    // 4 ns steps rounded to the nearest 5 ns tap; finer phase is lost
    function automatic logic [2:0] fine_taps(input logic [2:0] sel);
        return 3'((int'(sel) * seg_pkg::FINE_STEP_NS + seg_pkg::CLOCK_PERIOD_NS / 2)
                  / seg_pkg::CLOCK_PERIOD_NS);
    endfunction

    // a zero setting would hide every hit, so it acts as one crossing
    assign load_val = (stretch_bx == 3'h0) ? 3'h1 : stretch_bx;

    // pins are asynchronous: two flops, then the delay taps
    always_ff @(posedge clock) begin
        sync1_reg <= hit_pins;
        sync2_reg <= sync1_reg;
        dl_reg[0] <= sync2_reg;
        for (int i = 1; i < seg_pkg::DELAY_TAPS; i++) begin
            dl_reg[i] <= dl_reg[i-1];
        end
    end

    // per-channel tap select, mask and stretched level
    for (genvar l = 0; l < seg_pkg::LAYERS; l++) begin : g_layer
        for (genvar w = 0; w < seg_pkg::WIRE_GROUPS; w++) begin : g_wire
            assign delayed[l][w]      = dl_reg[fine_taps(delay_sel[l][w])][l][w];
            assign live[l][w]         = delayed[l][w] & ~chan_mask[l][w];
            assign hp.stretched[l][w] = (cnt_reg[l][w] != 3'h0);
        end
    end
    assign hp.raw = raw_reg;

    // sample once per crossing and restart the stretch on each hit
    always_ff @(posedge clock) begin
        if (srst) begin
            raw_reg <= '0;
            for (int l = 0; l < seg_pkg::LAYERS; l++) begin
                for (int w = 0; w < seg_pkg::WIRE_GROUPS; w++) begin
                    cnt_reg[l][w] <= 3'h0;
                end
            end
        end else if (bx_en) begin
            raw_reg <= live;
            for (int l = 0; l < seg_pkg::LAYERS; l++) begin
                for (int w = 0; w < seg_pkg::WIRE_GROUPS; w++) begin
                    if (live[l][w]) begin
                        cnt_reg[l][w] <= load_val;
                    end else if (cnt_reg[l][w] != 3'h0) begin
                        cnt_reg[l][w] <= cnt_reg[l][w] - 3'h1;
                    end
                end
            end
        end
    end
endmodule

// ==== rtl/raw_hit_store.sv ====
// ring memory holding one raw hit plane per crossing
`timescale 1ns/100ps
module raw_hit_store (
    input  wire logic                      clock,    // system clock
    input  wire logic                      wr_en,    // write one plane
    input  wire logic [seg_pkg::RAW_AW-1:0] wr_addr, // crossing slot
    input  wire logic [seg_pkg::RAW_W-1:0] wr_data,  // plane to store
    input  wire logic                      rd_en,    // read request
    input  wire logic [seg_pkg::RAW_AW-1:0] rd_addr, // slot to read
    output logic      [seg_pkg::RAW_W-1:0] rd_data   // registered read data
);
    logic [seg_pkg::RAW_W-1:0] mem [seg_pkg::RAW_DEPTH];

    // read data come one cycle after the request
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ==== rtl/seg_pkg.sv ====
// shared constants and types for the anode track-segment finder
package seg_pkg;
    localparam int LAYERS          = 6;
    localparam int WIRE_GROUPS     = 112;
    localparam int GROUP_SPAN      = 16;
    localparam int SEG_GROUPS      = WIRE_GROUPS / GROUP_SPAN;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int BX_PERIOD_NS    = 25;
    localparam int CLOCKS_PER_BX   = BX_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam logic [2:0] BX_DIV_LAST = 3'(CLOCKS_PER_BX - 1);
    localparam int DRIFT_WAIT_NS   = 50;
    localparam logic [1:0] WAIT_BX = 2'((DRIFT_WAIT_NS + BX_PERIOD_NS - 1) / BX_PERIOD_NS);
    localparam int FINE_STEP_NS    = 4;
    localparam int FINE_RANGE_NS   = 32;
    localparam int DELAY_TAPS      = (FINE_RANGE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STRETCH_NS      = 75;
    localparam logic [2:0] STRETCH_BX_TYPICAL = 3'(STRETCH_NS / BX_PERIOD_NS);
    localparam logic [2:0] QUAL_OFFSET = 3'h3;
    localparam logic [6:0] WG_LAST = 7'(WIRE_GROUPS - 1);
    localparam int BXN_W           = 12;
    localparam int SEG_W           = 16;
    localparam int SEG_VALID_BIT   = 15;
    localparam int SEG_QUAL_LSB    = 13;
    localparam int SEG_ACCEL_BIT   = 12;
    localparam int SEG_WG_LSB      = 5;
    localparam int SEG_BX_LSB      = 0;
    localparam int RAW_AW          = 5;
    localparam int RAW_DEPTH       = 32;
    localparam int RAW_W           = LAYERS * WIRE_GROUPS;
    localparam logic [9:0] RO_LAST = 10'(RAW_W - 1);

    typedef logic [LAYERS-1:0][WIRE_GROUPS-1:0] hit_plane_t;
    typedef logic [LAYERS-1:0][WIRE_GROUPS-1:0][2:0] delay_plane_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] key;
        logic       accel;
        logic [6:0] wg;
    } cand_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_SORT = 3'b100
    } state_t;
endpackage

// ==== testbench/stub_correlator_model.sv ====
// correlator-side model latching each reported segment pair
`timescale 1ns/100ps
module stub_correlator_model (
    input  wire logic        clock, // system clock
    input  wire logic [15:0] seg0,  // best segment word
    input  wire logic [15:0] seg1,  // second segment word
    output logic      [15:0] got0,  // last best word taken
    output logic      [15:0] got1   // last second word taken
);
    // words carry a segment only in their valid cycle
    always_ff @(posedge clock) begin
        if (seg0[15]) begin
            got0 <= seg0;
            got1 <= seg1;
        end
    end
endmodule

// ==== testbench/tb_anode_segment_finder.sv ====
// self-checking bench for the anode track-segment finder
`timescale 1ns/100ps
module tb_anode_segment_finder;
    logic                clock, srst, l1a, ce, ae, pol, pt, frz, rv, rb;
    seg_pkg::hit_plane_t hits, mask;
    logic [15:0]         s0, s1, g0, g1, w0, w1, exb;
    logic [11:0]         bxn, tag, tag0, lbx;
    int                  fails, n_tests, cyc;
    anode_segment_finder DUT (.clock(clock), .srst(srst), .hit_pins(hits), .delay_sel('0), .chan_mask(mask),
        .stretch_bx(3'h3), .pretrig_level(3'h2), .pattern_level(3'h4), .coll_enable(ce), .accel_enable(ae),
        .coll_high(pol), .level1_accept(l1a), .level1_bxn(lbx), .seg0_word(s0), .seg1_word(s1),
        .pretrig_pulse(pt), .bx_number(bxn), .raw_frozen(frz), .readout_bit(rb), .readout_valid(rv));
    stub_correlator_model model (.clock(clock), .seg0(s0), .seg1(s1), .got0(g0), .got1(g1));
    // own clock count since reset: a crossing every five clocks
    always @(posedge clock) cyc <= srst ? 0 : cyc + 1;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // mark one wire group in the chosen layers
    task automatic put(input int wg, input logic [5:0] lay);
        for (int l = 0; l < 6; l++)
            hits[l][wg] = lay[l];
    endtask
    // wait for the tag, drop the hits, then wait a bounded time for a segment; words clear one clock later
    task automatic run();
        int k;
        k = 0;
        while (pt !== 1'b1 && k < 40) begin
            @(posedge clock);
            #1;
            k++;
        end
        check("pretrig", {15'h0, pt}, 16'h1);
        check("crossing", {4'h0, bxn}, 16'(cyc / 5));
        tag = 12'(cyc / 5 - 1);
        exb = {11'h0, tag[4:0]};
        hits = '0;
        k = 0;
        while (s0[15] !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1;
            k++;
        end
        w0 = s0;
        w1 = s1;
        if (w0[15] === 1'b1)
            check("wait", 16'(k), 16'(seg_pkg::WAIT_BX * seg_pkg::CLOCKS_PER_BX + 1));
        @(posedge clock);
        #1;
        check("cleared", s0 | s1, 16'h0);
        repeat (40) @(posedge clock); // stretched hits die out before the next case
        #1;
    endtask
    task automatic t_point();
        put(20, 6'h3f);
        run();
        tag0 = tag;
        check("point", g0, 16'he280 | exb);
        check("empty", g1, 16'h0);
        check("frozen", {15'h0, frz}, 16'h1);
        pol = 1'b0;
        put(20, 6'h3f);
        run();
        check("polarity", g0, 16'hf280 | exb);
        pol = 1'b1;
    endtask
    task automatic t_accel();
        ce = 1'b0;
        put(100, 6'h1f);
        run();
        check("accel", g0, 16'hdc80 | exb);
        ce = 1'b1;
        ae = 1'b0;
    endtask
    task automatic t_two();
        put(5, 6'h0f);
        put(90, 6'h3f);
        run();
        check("best", g0, 16'heb40 | exb);
        check("second", g1, 16'ha0a0 | exb);
    endtask
    task automatic t_tie();
        put(40, 6'h3f);
        put(41, 6'h3f);
        run();
        check("tie", g0, 16'he520 | exb);
        check("span", g1, 16'h0);
    endtask
    // masked layers leave too few hits for a pattern
    task automatic t_mask();
        for (int l = 2; l < 6; l++)
            mask[l][60] = 1'b1;
        put(60, 6'h3f);
        run();
        check("masked", w0, 16'h0);
        mask = '0;
        lbx = ~tag0;
        l1a = 1'b1;
        @(posedge clock);
        #1;
        l1a = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("other accept", {15'h0, frz}, 16'h1);
    endtask
    // matching accept shifts the frozen plane out lsb first, then the store thaws
    task automatic t_read();
        lbx = tag0;
        l1a = 1'b1;
        @(posedge clock);
        #1;
        l1a = 1'b0;
        check("ro start", {15'h0, rv}, 16'h0);
        @(posedge clock);
        #1;
        for (int i = 0; i < seg_pkg::RAW_W; i++) begin
            check("ro bit", {14'h0, rv, rb}, {14'h0, 1'b1, 1'(i % seg_pkg::WIRE_GROUPS == 20)});
            @(posedge clock);
            #1;
        end
        check("ro end", {14'h0, rv, frz}, 16'h0);
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // a hang past twenty microseconds ends the run as a failure
    initial begin
        #20000;
        fails++;
        final_report();
    end
    initial begin
        {srst, ce, ae, pol, l1a, lbx, hits, mask, fails, n_tests} = '0;
        srst = 1'b1;
        {ce, ae, pol} = 3'h7;
        repeat (4) @(posedge clock);
        #1;
        srst = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        t_point();
        t_accel();
        t_two();
        t_tie();
        t_mask();
        t_read();
        final_report();
    end
endmodule
